//--- inc/cpcr_pkg.sv
// Purpose: Shared constants for the channel power control register block
// Assumes: Byte-wide registers reached over an internal register port
// Notes: Functional notes follow
`default_nettype none
package cpcr_pkg;
	localparam logic [7:0] CPCR_ADDR_IN_EN = 8'h73;
	localparam logic [7:0] CPCR_ADDR_SLOT_EN = 8'h74;
	localparam logic [7:0] CPCR_ADDR_PWR = 8'h75;
	localparam logic [7:0] CPCR_ADDR_STS = 8'h76;
	localparam logic [7:0] CPCR_RST_IN_EN = 8'hC0;
	localparam logic [7:0] CPCR_RST_SLOT_EN = 8'h00;
	localparam logic [7:0] CPCR_RST_PWR = 8'h00;
	localparam int CPCR_BIT_MICBIAS = 7;
	localparam int CPCR_BIT_CONV = 6;
	localparam int CPCR_BIT_PLL = 5;
	localparam int CPCR_BIT_DYN = 4;
	localparam int CPCR_BIT_VAD = 0;
	localparam logic [2:0] CPCR_MODE_SLEEP = 3'h4;
	localparam logic [2:0] CPCR_MODE_IDLE = 3'h6;
	localparam logic [2:0] CPCR_MODE_RUN = 3'h7;
	// Power-up and power-down settling, in nanoseconds and in cycles of 40 ns
	localparam int CPCR_SEQ_NS = 400;
	localparam int CPCR_CLK_NS = 40;
	localparam logic [7:0] CPCR_SEQ_CYC = 8'((CPCR_SEQ_NS + CPCR_CLK_NS - 1) / CPCR_CLK_NS);
	typedef enum logic [1:0] {CPCR_OFF, CPCR_UP, CPCR_ON, CPCR_DOWN} cpcr_pwr_e;
endpackage : cpcr_pkg
`default_nettype wire

//--- rtl/cpcr_chan_seq.sv
// Purpose: Power sequencer for one converter channel
// Assumes: Request is a level from the register logic on core_clk
// Notes: Status rises only after a full settling count
`timescale 1ns/10ps
`default_nettype none
module cpcr_chan_seq
	import cpcr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic power_req,
	// Status
	output logic powered
);
	cpcr_pwr_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic powered_reg, powered_next;

	// Next-state sequencing with settle counter
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		powered_next = powered_reg;
		case (state_reg)
			CPCR_OFF:
			begin
				if (power_req)
				begin
					state_next = CPCR_UP;
					cnt_next = CPCR_SEQ_CYC;
				end
			end
			CPCR_UP:
			begin
				if (!power_req)
					state_next = CPCR_OFF; // Abort before status ever rose
				else if (cnt_reg == 8'h01)
				begin
					state_next = CPCR_ON;
					powered_next = 1'b1;
				end
				else
					cnt_next = cnt_reg - 8'h01;
			end
			CPCR_ON:
			begin
				if (!power_req)
				begin
					state_next = CPCR_DOWN;
					cnt_next = CPCR_SEQ_CYC;
				end
			end
			CPCR_DOWN:
			begin
				// Status stays high until the channel is really quiet
				if (cnt_reg == 8'h01)
				begin
					state_next = CPCR_OFF;
					powered_next = 1'b0;
				end
				else
					cnt_next = cnt_reg - 8'h01;
			end
			default:
			begin
				state_next = CPCR_OFF;
				powered_next = 1'b0;
			end
		endcase
	end

	// Registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg <= CPCR_OFF;
			cnt_reg <= 8'h00;
			powered_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			powered_reg <= powered_next;
		end
	end

	assign powered = powered_reg;
endmodule : cpcr_chan_seq
`default_nettype wire

//--- rtl/cpcr_regs.sv
// Purpose: Channel enable, slot enable, power configuration and status registers
// Assumes: Serial control decoding elsewhere presents byte writes and reads
// Notes: Reads return data one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module cpcr_regs
	import cpcr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port from the serial control decoder
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Recording activity from the audio path and the sleep mode input
	input wire logic recording,
	input wire logic sleep_mode,
	// Controls to the analog and audio blocks
	output logic mic_bias_power,
	output logic pll_power,
	output logic voice_detect_on,
	output logic [3:0] channel_power,
	output logic [3:0] slot_drive,
	output logic [2:0] device_mode_state
);
	logic [3:0] in_en_reg, in_en_next;
	logic [3:0] slot_reg, slot_next;
	logic [7:0] pwr_reg, pwr_next;
	logic [3:0] req_reg, req_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [3:0] powered;
	logic [7:0] sts_word;
	logic [2:0] mode_reg, mode_next;

	// Channel limit for the dynamic set; reserved codes fall back to two
	function automatic logic [3:0] chan_mask(input logic [1:0] sel);
		chan_mask = (sel == 2'h1) ? 4'hF : 4'hC;
	endfunction : chan_mask

	// One sequencer per channel
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_seq
			cpcr_chan_seq u_seq (
				.core_clk(core_clk),
				.rst(rst),
				.power_req(req_reg[gi]),
				.powered(powered[gi])
			);
		end
	endgenerate

	assign sts_word = {powered[3], powered[2], 6'h00};

	// Control register writes; only the upper nibble of the enables is kept
	always_comb
	begin
		in_en_next = in_en_reg;
		slot_next = slot_reg;
		pwr_next = pwr_reg;
		if (reg_wr)
		begin
			case (reg_addr)
				CPCR_ADDR_IN_EN:
				begin
					in_en_next = reg_wdata[7:4];
				end
				CPCR_ADDR_SLOT_EN:
				begin
					slot_next = reg_wdata[7:4];
				end
				CPCR_ADDR_PWR:
				begin
					pwr_next = reg_wdata; // bit 1 is stored as written
				end
				default:
				begin
					// Status and unmapped addresses ignore writes
					pwr_next = pwr_reg;
				end
			endcase
		end
	end

	// Control registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			in_en_reg <= CPCR_RST_IN_EN[7:4];
			slot_reg <= CPCR_RST_SLOT_EN[7:4];
			pwr_reg <= CPCR_RST_PWR;
		end
		else
		begin
			in_en_reg <= in_en_next;
			slot_reg <= slot_next;
			pwr_reg <= pwr_next;
		end
	end

	// Channel power requests to the sequencers
	always_comb
	begin
		logic [3:0] want;
		want = 4'h0;
		// Converter power gates every enabled channel
		if (pwr_reg[CPCR_BIT_CONV])
			want = in_en_reg;
		if (pwr_reg[CPCR_BIT_DYN])
			want = want & chan_mask(pwr_reg[3:2]);
		// Without dynamic switching a non-empty set is frozen while recording,
		// so a running capture keeps its channels mid-stream and drops them all only once no channel is wanted
		if (pwr_reg[CPCR_BIT_DYN] || !recording || (req_reg == 4'h0) || (want == 4'h0))
			req_next = want;
		else
			req_next = req_reg;
	end

	// Request register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			req_reg <= 4'h0;
		else
			req_reg <= req_next;
	end

	// Read data; the answer stands until the next read
	always_comb
	begin
		rdata_next = rdata_reg;
		rvalid_next = reg_rd;
		if (reg_rd)
		begin
			case (reg_addr)
				CPCR_ADDR_IN_EN:
				begin
					rdata_next = {in_en_reg, 4'h0};
				end
				CPCR_ADDR_SLOT_EN:
				begin
					rdata_next = {slot_reg, 4'h0};
				end
				CPCR_ADDR_PWR:
				begin
					rdata_next = pwr_reg;
				end
				CPCR_ADDR_STS:
				begin
					rdata_next = sts_word;
				end
				default:
				begin
					rdata_next = 8'h00; // Unmapped reads as zero
				end
			endcase
		end
	end

	// Read answer registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Mode status; registered so the output is glitch free, one cycle behind
	always_comb
	begin
		mode_next = CPCR_MODE_IDLE;
		if (sleep_mode)
			mode_next = CPCR_MODE_SLEEP;
		else if (powered != 4'h0)
			mode_next = CPCR_MODE_RUN;
	end

	// Mode register; comes out of reset as asleep
	always_ff @(posedge core_clk)
	begin
		if (rst)
			mode_reg <= CPCR_MODE_SLEEP;
		else
			mode_reg <= mode_next;
	end

	// Outputs; bit order 3 is the first channel
	assign mic_bias_power = pwr_reg[CPCR_BIT_MICBIAS];
	assign pll_power = pwr_reg[CPCR_BIT_PLL];
	assign voice_detect_on = pwr_reg[CPCR_BIT_VAD];
	assign channel_power = powered;
	assign slot_drive = slot_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign device_mode_state = mode_reg;
endmodule : cpcr_regs
`default_nettype wire

//--- verification/cpcr_host.sv
// Purpose: Host side of the register port
// Assumes: One request at a time
// Notes: Keeps reserved bits and unused codes at zero
`timescale 1ns/10ps
`default_nettype none
module cpcr_host (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// Idle request lines from time zero
	initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
	// Byte write held for one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d & ((a == 8'h75) ? 8'hF5 : 8'hF0);
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Byte read; data taken once the answer has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
endmodule : cpcr_host
`default_nettype wire

//--- verification/cpcr_regs_chk.sv
// Purpose: Port checks for the register block
// Assumes: Top module ports only
// Notes: Bound after the module
`timescale 1ns/10ps
`default_nettype none
module cpcr_regs_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	// Mode input and controls
	input wire logic sleep_mode,
	input wire logic mic_bias_power,
	input wire logic pll_power,
	input wire logic voice_detect_on,
	input wire logic [3:0] channel_power,
	input wire logic [3:0] slot_drive,
	input wire logic [2:0] device_mode_state
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Steps of a power write and of a read answer
	sequence s_pwr_wr;
		reg_wr && reg_addr == 8'h75;
	endsequence
	sequence s_answer;
		##1 reg_rvalid;
	endsequence
	a_read_answer: assert property (reg_rd |-> s_answer)
		else $error("read not answered");
	a_bias_write: assert property (s_pwr_wr |=> mic_bias_power == $past(reg_wdata[7]))
		else $error("bias control wrong");
	a_pll_write: assert property (s_pwr_wr |=> pll_power == $past(reg_wdata[5]))
		else $error("pll control wrong");
	a_vad_write: assert property (s_pwr_wr |=> voice_detect_on == $past(reg_wdata[0]))
		else $error("voice detect control wrong");
	a_slot_write: assert property (reg_wr && reg_addr == 8'h74 |=>
		slot_drive == $past(reg_wdata[7:4])) else $error("slot drive wrong");
	// Settling must run before any channel reports power
	a_conv_settle: assert property (reg_wr && reg_addr == 8'h75 && reg_wdata[6] &&
		channel_power == 4'h0 |=> (channel_power == 4'h0) [*8]) else $error("power too early");
	a_mode_sleep: assert property (sleep_mode [*3] |-> device_mode_state == 3'h4)
		else $error("sleep mode state wrong");
	a_mode_active: assert property (!sleep_mode [*3] |-> device_mode_state ==
		(($past(channel_power) != 4'h0) ? 3'h7 : 3'h6)) else $error("active mode state wrong");
endmodule : cpcr_regs_chk
bind cpcr_regs cpcr_regs_chk cpcr_regs_chk_inst (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rvalid(reg_rvalid), .sleep_mode(sleep_mode), .mic_bias_power(mic_bias_power),
	.pll_power(pll_power), .voice_detect_on(voice_detect_on), .channel_power(channel_power),
	.slot_drive(slot_drive), .device_mode_state(device_mode_state));
`default_nettype wire

//--- verification/tb_cpcr_regs.sv
// Purpose: Register and power checks
// Assumes: 25 MHz clock
// Notes: Waits of 16 cycles cover settling
`timescale 1ns/10ps
`default_nettype none
module tb_cpcr_regs;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic recording = 1'b0;
	logic sleep_mode = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic reg_wr, reg_rd, reg_rvalid, mic_bias_power, pll_power, voice_detect_on;
	logic [3:0] channel_power, slot_drive;
	logic [2:0] device_mode_state;
	int num_errors = 0;
	int tests_run = 0;
	// Clock
	always #20 core_clk = ~core_clk;
	cpcr_host cpcr_host_inst (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	cpcr_regs cpcr_regs_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .recording(recording), .sleep_mode(sleep_mode),
		.mic_bias_power(mic_bias_power), .pll_power(pll_power),
		.voice_detect_on(voice_detect_on), .channel_power(channel_power),
		.slot_drive(slot_drive), .device_mode_state(device_mode_state));
	// Compare one value
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Read a register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		cpcr_host_inst.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
		chk("rvalid", 8'h01, {7'h00, reg_rvalid});
	endtask : rchk
	// Write, then let the power sequencers settle
	task automatic wset(input logic [7:0] a, input logic [7:0] d);
		cpcr_host_inst.wr(a, d);
		repeat (16) @(negedge core_clk);
	endtask : wset
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// Hang guard, well past the expected run
	initial
	begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rchk(8'h73, 8'hC0);
		rchk(8'h74, 8'h00);
		rchk(8'h75, 8'h00);
		rchk(8'h76, 8'h00);
		rchk(8'h10, 8'h00);
		$display("reset values done");
		cpcr_host_inst.wr(8'h73, 8'h30);
		rchk(8'h73, 8'h30);
		cpcr_host_inst.wr(8'h74, 8'hA0);
		rchk(8'h74, 8'hA0);
		chk("slot_drive", 8'h0A, {4'h0, slot_drive});
		cpcr_host_inst.wr(8'h75, 8'hA1);
		rchk(8'h75, 8'hA1);
		chk("controls", 8'h07, {5'h0, mic_bias_power, pll_power, voice_detect_on});
		cpcr_host_inst.wr(8'h76, 8'hFF);
		rchk(8'h76, 8'h00);
		$display("access done");
		cpcr_host_inst.wr(8'h73, 8'hC0);
		wset(8'h75, 8'h40);
		chk("channel_power", 8'h0C, {4'h0, channel_power});
		rchk(8'h76, 8'hC0);
		chk("mode", 8'h07, {5'h0, device_mode_state});
		@(posedge core_clk);
		recording <= 1'b1;
		wset(8'h73, 8'h80);
		chk("channel_power", 8'h0C, {4'h0, channel_power});
		wset(8'h75, 8'h54);
		chk("channel_power", 8'h08, {4'h0, channel_power});
		wset(8'h73, 8'hF0);
		chk("channel_power", 8'h0F, {4'h0, channel_power});
		wset(8'h75, 8'h50);
		chk("channel_power", 8'h0C, {4'h0, channel_power});
		@(posedge core_clk);
		recording <= 1'b0;
		wset(8'h75, 8'h00);
		chk("channel_power", 8'h00, {4'h0, channel_power});
		chk("mode", 8'h06, {5'h0, device_mode_state});
		@(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk("mode", 8'h04, {5'h0, device_mode_state});
		$display("power done");
		// Reset again after use; enables were left at all four channels
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rchk(8'h73, 8'hC0);
		rchk(8'h75, 8'h00);
		chk("channel_power", 8'h00, {4'h0, channel_power});
		$display("second reset done");
		conclude();
	end
endmodule : tb_cpcr_regs
`default_nettype wire
